//--- rtl/iwd_top.sv
// I/O port watchdog timer with sixteen selectable intervals
`timescale 1ns/1ps
`default_nettype none
`include "iwd_map.svh"
module iwd_top #(
    parameter int unsigned TICK_CYCLES = `IWD_TICK_CYCLES,
    parameter int unsigned RST_PULSE = `IWD_RST_PULSE_CYCLES
) (
    input wire logic core_clk,
    input wire logic rstn,
    input wire logic io_wr,
    input wire logic [15:0] io_addr,
    input wire logic [15:0] io_wdata,
    output logic sys_reset,
    output logic armed
);
    // ********************************************************
    // Helper functions
    // ********************************************************

    // One address compare serves both ports
    function automatic logic port_hit(
        input logic wr,
        input logic [15:0] addr,
        input logic [15:0] port
    );
        return wr && (addr == port);
    endfunction

    // Seconds = 2 * (15 - code); code F leaves no delay at all
    function automatic logic [5:0] interval_secs(
        input logic [`IWD_CODE_W-1:0] sel
    );
        logic [5:0] steps;
        steps = 6'(4'hf - sel);
        return 6'(`IWD_STEP_S * steps);
    endfunction

    // ********************************************************
    // Port decode
    // ********************************************************

    logic arm_wr;
    logic disarm_wr;
    logic [`IWD_CODE_W-1:0] code;
    logic [5:0] load_secs;

    assign arm_wr = port_hit(io_wr, io_addr, `IWD_ARM_PORT);
    assign disarm_wr = port_hit(io_wr, io_addr, `IWD_DISARM_PORT);

    // Upper data bits ignored; only the low nibble carries the code
    assign code = io_wdata[`IWD_CODE_LSB +: `IWD_CODE_W];
    assign load_secs = interval_secs(code);

    // ********************************************************
    // Timebase
    // ********************************************************

    logic tick;

    // Exact crystal count sits well inside the allowed tolerance
    iwd_tick #(
        .CYCLES(TICK_CYCLES)
    ) u_tick (
        .core_clk(core_clk),
        .rstn(rstn),
        .restart(arm_wr),
        .tick(tick)
    );

    // ********************************************************
    // Countdown signals
    // ********************************************************

    iwd_pkg::iwd_state_t state_ff;
    iwd_pkg::iwd_state_t nxt_state;
    logic [5:0] secs_ff;
    logic [5:0] nxt_secs;
    logic [7:0] pulse_ff;
    logic [7:0] nxt_pulse;
    logic sys_reset_ff;
    logic armed_ff;
    logic take_arm;
    logic load_now;
    logic counting;
    logic expire;
    logic pulse_done;

    // A write to the disarming port always beats an arming write
    assign take_arm = arm_wr && !disarm_wr;

    // Writes that land during the reset pulse are dropped
    assign load_now = take_arm && (state_ff != iwd_pkg::IWD_FIRE);

    assign counting = (state_ff == iwd_pkg::IWD_RUN) && !disarm_wr;
    assign expire = tick && (secs_ff == 6'h01);
    assign pulse_done = (pulse_ff == 8'(RST_PULSE - 1));

    // ********************************************************
    // Next state
    // ********************************************************

    always_comb begin
        nxt_state = state_ff;
        unique case (state_ff)
            iwd_pkg::IWD_IDLE: begin
                if (take_arm) begin
                    if (load_secs == 6'h00) begin
                        nxt_state = iwd_pkg::IWD_FIRE;
                    end else begin
                        nxt_state = iwd_pkg::IWD_RUN;
                    end
                end
            end
            iwd_pkg::IWD_RUN: begin
                if (disarm_wr) begin
                    nxt_state = iwd_pkg::IWD_IDLE;
                end else if (arm_wr) begin
                    // Rearming with code F fires at once
                    if (load_secs == 6'h00) begin
                        nxt_state = iwd_pkg::IWD_FIRE;
                    end
                end else if (expire) begin
                    nxt_state = iwd_pkg::IWD_FIRE;
                end
            end
            iwd_pkg::IWD_FIRE: begin
                // Reset pulse runs to completion; the system is going down
                if (pulse_done) begin
                    nxt_state = iwd_pkg::IWD_IDLE;
                end
            end
            default: begin
                nxt_state = iwd_pkg::IWD_IDLE;
            end
        endcase
    end

    // ********************************************************
    // Next second count
    // ********************************************************

    always_comb begin
        nxt_secs = secs_ff;
        if (load_now) begin
            nxt_secs = load_secs;
        end else if (counting && tick) begin
            nxt_secs = secs_ff - 6'h01;
        end
    end

    // ********************************************************
    // Next pulse count
    // ********************************************************

    always_comb begin
        nxt_pulse = 8'h00;
        if (state_ff == iwd_pkg::IWD_FIRE) begin
            nxt_pulse = pulse_ff + 8'h01;
        end
    end

    // ********************************************************
    // State register
    // ********************************************************

    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            state_ff <= iwd_pkg::IWD_IDLE;
        end else begin
            state_ff <= nxt_state;
        end
    end

    // ********************************************************
    // Second counter
    // ********************************************************

    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            secs_ff <= 6'h00;
        end else begin
            secs_ff <= nxt_secs;
        end
    end

    // ********************************************************
    // Pulse counter
    // ********************************************************

    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            pulse_ff <= 8'h00;
        end else begin
            pulse_ff <= nxt_pulse;
        end
    end

    // ********************************************************
    // Outputs
    // ********************************************************

    // Both status pins come straight from flops, so no decode glitch
    // can ever reach the system reset line
    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            sys_reset_ff <= 1'b0;
        end else begin
            sys_reset_ff <= (nxt_state == iwd_pkg::IWD_FIRE);
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            armed_ff <= 1'b0;
        end else begin
            armed_ff <= (nxt_state == iwd_pkg::IWD_RUN);
        end
    end

    assign sys_reset = sys_reset_ff;
    assign armed = armed_ff;
endmodule
`default_nettype wire

//--- rtl/iwd_map.svh
// Port addresses, field positions and timing counts of the I/O watchdog
`ifndef IWD_MAP_SVH
`define IWD_MAP_SVH
`define IWD_DISARM_PORT 16'h0441
`define IWD_ARM_PORT 16'h0443
`define IWD_CODE_LSB 0
`define IWD_CODE_W 4
`define IWD_STEP_S 2
`define IWD_CLK_HZ 200000000
`define IWD_TICK_CYCLES (`IWD_CLK_HZ)
`define IWD_RST_PULSE_CYCLES 16
`endif

//--- rtl/iwd_pkg.sv
// Types of the I/O watchdog
`default_nettype none
package iwd_pkg;
    typedef enum logic [1:0] {
        IWD_IDLE = 2'b00,
        IWD_RUN = 2'b01,
        IWD_FIRE = 2'b11
    } iwd_state_t;
endpackage
`default_nettype wire

//--- rtl/iwd_tick.sv
// One-second tick generator for the I/O watchdog
`timescale 1ns/1ps
`default_nettype none
`include "iwd_map.svh"
module iwd_tick #(
    parameter int unsigned CYCLES = `IWD_TICK_CYCLES
) (
    input wire logic core_clk,
    input wire logic rstn,
    input wire logic restart,
    output logic tick
);
    logic [31:0] cnt_ff;
    // Restart aligns the second boundary to the arming write
    always_ff @(posedge core_clk) begin
        if (!rstn || restart) begin
            cnt_ff <= 32'h0000_0000;
        end else if (cnt_ff == 32'(CYCLES - 1)) begin
            cnt_ff <= 32'h0000_0000;
        end else begin
            cnt_ff <= cnt_ff + 32'h0000_0001;
        end
    end
    assign tick = (cnt_ff == 32'(CYCLES - 1)) && !restart;
endmodule
`default_nettype wire

//--- test/iwd_props.sv
// Assertion checker of the I/O watchdog
`timescale 1ns/1ps
`default_nettype none
module iwd_props (
    input wire logic core_clk,
    input wire logic rstn,
    input wire logic io_wr,
    input wire logic [15:0] io_addr,
    input wire logic [15:0] io_wdata,
    input wire logic sys_reset,
    input wire logic armed
);
// ****
// Properties, timed for a two-cycle tick and a four-cycle pulse
// ****
default clocking @(posedge core_clk); endclocking
default disable iff (!rstn);
wire logic arm_w = io_wr && io_addr == 16'h0443 && !sys_reset;
wire logic dis_w = io_wr && io_addr == 16'h0441 && !sys_reset;
wire logic [3:0] code = io_wdata[3:0];
property p_arm; arm_w && code != 4'hF |=> armed; endproperty
a_arm: assert property (p_arm) else $error("arm not taken");
property p_zero; arm_w && code == 4'hF |=> sys_reset; endproperty
a_zero: assert property (p_zero) else $error("code F late");
property p_dis; dis_w |=> !armed && !sys_reset; endproperty
a_dis: assert property (p_dis) else $error("disarm lost");
property p_cause; !armed && !sys_reset && !io_wr |=> !sys_reset; endproperty
a_cause: assert property (p_cause) else $error("stray reset");
property p_tol; arm_w && code == 4'hE ##1 !io_wr [*3] |-> armed; endproperty
a_tol: assert property (p_tol) else $error("fired early");
property p_fire; arm_w && code == 4'hE ##1 !io_wr [*6] |-> !armed; endproperty
a_fire: assert property (p_fire) else $error("never fired");
property p_reload; armed && arm_w && code == 4'hE ##1 !io_wr [*3] |-> armed;
endproperty
a_reload: assert property (p_reload) else $error("no reload");
property p_pulse; $rose(sys_reset) |-> sys_reset [*4] ##1 !sys_reset;
endproperty
a_pulse: assert property (p_pulse) else $error("pulse length");
c_arm: cover property (arm_w ##1 armed);
c_fire: cover property ($rose(sys_reset));
c_dis: cover property (dis_w && armed);
endmodule
bind iwd_top iwd_props iwd_props_i (.core_clk(core_clk), .rstn(rstn),
    .io_wr(io_wr), .io_addr(io_addr), .io_wdata(io_wdata),
    .sys_reset(sys_reset), .armed(armed));
`default_nettype wire

//--- test/tb_top.sv
// Testbench of the I/O watchdog
`timescale 1ns/1ps
`default_nettype none
module tb_top;
// ****
// Bench
// ****
`define CHK(a, b) begin compares++; if ((a) !== (b)) begin num_errors++; \
    $display("ERROR %0t mismatch", $time); end end
logic core_clk = 0, rstn = 0, io_wr = 0, sys_reset, armed, seen;
logic [15:0] io_addr = 0, io_wdata = 0;
int num_errors = 0, compares = 0, n;
always #2.5 core_clk = ~core_clk;
// Tick cut to two cycles so all sixteen codes run quickly
iwd_top #(.TICK_CYCLES(2), .RST_PULSE(4)) iwd_top_i (.core_clk(core_clk),
    .rstn(rstn), .io_wr(io_wr), .io_addr(io_addr), .io_wdata(io_wdata),
    .sys_reset(sys_reset), .armed(armed));
task automatic wr(input logic [15:0] a, input logic [15:0] d);
    io_addr = a;
    io_wdata = d;
    io_wr = 1'b1;
    @(negedge core_clk);
    // One idle cycle keeps back-to-back calls off the same strobe edge
    io_wr = 1'b0;
    @(negedge core_clk);
endtask
task automatic end_sim;
    $display("errors %0d compares %0d", num_errors, compares);
    if (num_errors == 0 && compares > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
endtask
initial begin
    #20000;
    num_errors++;
    end_sim;
end
initial begin
    repeat (16) @(negedge core_clk);
    rstn = 1'b1;
    for (int c = 0; c < 16; c++) begin
        wr(16'h0443, 16'(c));
        // The task returns on the second falling edge after the arming edge
        n = 2;
        while (!sys_reset && n < 200) begin
            @(negedge core_clk);
            n++;
        end
        seen = (n * 5 >= 16 * (15 - c)) && (n * 5 <= 24 * (15 - c) + 10);
        `CHK(seen, 1'b1)
        // Writes are ignored while the pulse stands, so let it end
        repeat (6) @(negedge core_clk);
    end
    $display("interval test done");
    wr(16'h0443, 16'h0000);
    wr(16'h0441, 16'hFFFF);
    `CHK(armed, 1'b0)
    seen = 1'b0;
    repeat (70) begin
        @(negedge core_clk);
        seen = seen | sys_reset;
    end
    `CHK(seen, 1'b0)
    wr(16'h0442, 16'h000E);
    `CHK(armed, 1'b0)
    $display("disarm test done");
    wr(16'h0443, 16'h000E);
    `CHK(armed, 1'b1)
    @(negedge core_clk);
    wr(16'h0443, 16'h000E);
    @(negedge core_clk);
    `CHK(armed, 1'b1)
    repeat (2) @(negedge core_clk);
    `CHK(sys_reset, 1'b1)
    repeat (10) @(negedge core_clk);
    `CHK(armed, 1'b0)
    `CHK(sys_reset, 1'b0)
    $display("reload test done");
    wr(16'h0443, 16'h0000);
    rstn = 1'b0;
    repeat (2) @(negedge core_clk);
    `CHK(armed, 1'b0)
    rstn = 1'b1;
    repeat (2) @(negedge core_clk);
    `CHK(sys_reset, 1'b0)
    $display("reset test done");
    end_sim;
end
endmodule
`default_nettype wire
